//--- include/vtarget_pkg.sv
// Constants and types shared by the output voltage target block.
`default_nettype none
package vtarget_pkg;
	// Register offsets.
	localparam logic [7:0] OFS_TARGET_HIGH = 8'h00;
	localparam logic [7:0] OFS_TARGET_LOW = 8'h01;
	localparam logic [7:0] OFS_VENDOR_CFG = 8'h02;
	localparam logic [7:0] OFS_DISCH_STRENGTH = 8'h03;
	localparam logic [7:0] OFS_DISCH_SEQ0 = 8'h04;
	localparam logic [7:0] OFS_DISCH_SEQ1 = 8'h05;
	localparam logic [7:0] OFS_DISCH_OVERRIDE = 8'h06;
	localparam logic [7:0] OFS_STATUS = 8'h07;
	// Field positions.
	localparam int BIT_DIV_SEL = 0;
	localparam int BIT_OVR_EN = 0;
	localparam int BIT_OVR_ON = 1;
	localparam int BIT_SEQ_OFF = 0;
	localparam int BIT_SEQ_DISABLED = 0;
	localparam int STRENGTH_W = 2;
	localparam int CODE_W = 12;
	// Reset values.
	localparam logic [7:0] RST_TARGET_HIGH = 8'h01;
	localparam logic [7:0] RST_TARGET_LOW = 8'hF4;
	localparam logic [7:0] RST_VENDOR_CFG = 8'h00;
	localparam logic [1:0] RST_STRENGTH = 2'h0;
	localparam logic [7:0] RST_SEQ = 8'h00;
	localparam logic [1:0] RST_OVERRIDE = 2'h0;
	// Range limits in code units: 1.0 V and 24 V at 10 mV, 3.3 V and 48 V at 20 mV.
	localparam logic [11:0] CODE_MIN_DIV10 = 12'h064;
	localparam logic [11:0] CODE_MAX_DIV10 = 12'h960;
	localparam logic [11:0] CODE_MIN_DIV20 = 12'h0A5;
	localparam logic [11:0] CODE_MAX_DIV20 = 12'h960;
	// Step size per code unit in millivolts.
	localparam int STEP_MV_DIV10 = 10;
	localparam int STEP_MV_DIV20 = 20;
	localparam logic [1:0] STRENGTH_MAX = 2'h3;
	typedef enum logic [1:0] {RAMP_IDLE, RAMP_UP, RAMP_DOWN} ramp_e;
	typedef struct packed {
		logic en;
		logic [1:0] strength;
	} disch_s;
endpackage
`default_nettype wire

//--- verilog/output_voltage_target_dvs.sv
// Output voltage target, reference slewing and discharge control.
//
// The register addresses and strobed register access were left to the implementer.
`default_nettype none
// What this block does
// - Sample feedback pin before start, hold choice until enable is low with the converter off, or reset.
// - Internal feedback selected means loop senses output pin, not feedback pin.
// - Divider bit clear: targets 1.0 V to 24 V in 10 mV steps.
// - Divider bit set: targets 3.3 V to 48 V in 20 mV steps.
// - Twelve-bit target from high field low nibble and low field byte.
// - Target written below range reads back as lowest allowed code.
// - Target written above range reads back as highest allowed code.
// - Target change while running moves reference gradually.
// - Reference moves at most one increment per slope interval.
// - Target written while off loads without ramping; soft-start uses it.
// - Power-save blocks negative inductor current.
// - Active scaling enables discharge throughout every falling ramp only.
// - Falling active ramp uses maximum discharge strength.
// - Discharge strength and sequence come from software registers.
// - Override setting forces discharge on or off above the sequence.
module output_voltage_target_dvs #(
	parameter int RAMP_STEP = 1
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic feedback_sense_pin,
	input wire logic enable_pin,
	input wire logic conv_running,
	input wire logic power_save_operation,
	input wire logic nvm_active_slew,
	input wire logic [7:0] nvm_slope_interval,
	output logic internal_feedback_sel,
	output logic loop_sense_vout,
	output logic [11:0] reference_code,
	output logic [4:0] step_mv,
	output logic ramp_active,
	output logic neg_current_block,
	output vtarget_pkg::disch_s discharge
);
	////////////////////////////////////////////////////////////////////////////
	logic sense_meta_r;
	logic sense_sync_r;
	logic en_meta_r;
	logic en_sync_r;
	logic feedback_sel_r;
	logic [7:0] tgt_high_r;
	logic [7:0] tgt_low_r;
	logic [7:0] vcfg_r;
	logic [1:0] strength_r;
	logic [7:0] seq0_r;
	logic [7:0] seq1_r;
	logic [1:0] ovr_r;
	logic [7:0] rdata_r;
	logic [11:0] ref_r;
	logic [11:0] ref_nxt;
	logic [7:0] slope_cnt_r;
	logic slope_tick;
	vtarget_pkg::ramp_e ramp_state;
	vtarget_pkg::disch_s disch_r;
	vtarget_pkg::disch_s disch_nxt;

	// The pins cross into mclk through two flip-flops.
	always_ff @(posedge mclk) begin
		if (rst) begin
			sense_meta_r <= 1'b0;
			sense_sync_r <= 1'b0;
			en_meta_r <= 1'b0;
			en_sync_r <= 1'b0;
		end else begin
			sense_meta_r <= feedback_sense_pin;
			sense_sync_r <= sense_meta_r;
			en_meta_r <= enable_pin;
			en_sync_r <= en_meta_r;
		end
	end

	// The feedback choice follows the pin only while enable is low and the converter is off.
	always_ff @(posedge mclk) begin
		if (rst) begin
			feedback_sel_r <= 1'b0;
		end else if (!en_sync_r && !conv_running) begin
			feedback_sel_r <= sense_sync_r;
		end
	end
	assign internal_feedback_sel = feedback_sel_r;
	assign loop_sense_vout = feedback_sel_r;

	////////////////////////////////////////////////////////////////////////////
	// Register decode.
	wire wr_high = reg_wr && reg_addr == vtarget_pkg::OFS_TARGET_HIGH;
	wire wr_low = reg_wr && reg_addr == vtarget_pkg::OFS_TARGET_LOW;
	wire wr_vcfg = reg_wr && reg_addr == vtarget_pkg::OFS_VENDOR_CFG;
	wire wr_str = reg_wr && reg_addr == vtarget_pkg::OFS_DISCH_STRENGTH;
	wire wr_seq0 = reg_wr && reg_addr == vtarget_pkg::OFS_DISCH_SEQ0;
	wire wr_seq1 = reg_wr && reg_addr == vtarget_pkg::OFS_DISCH_SEQ1;
	wire wr_ovr = reg_wr && reg_addr == vtarget_pkg::OFS_DISCH_OVERRIDE;
	wire div_sel = vcfg_r[vtarget_pkg::BIT_DIV_SEL];

	always_ff @(posedge mclk) begin
		if (rst) begin
			tgt_high_r <= vtarget_pkg::RST_TARGET_HIGH;
			tgt_low_r <= vtarget_pkg::RST_TARGET_LOW;
			vcfg_r <= vtarget_pkg::RST_VENDOR_CFG;
			strength_r <= vtarget_pkg::RST_STRENGTH;
			seq0_r <= vtarget_pkg::RST_SEQ;
			seq1_r <= vtarget_pkg::RST_SEQ;
			ovr_r <= vtarget_pkg::RST_OVERRIDE;
		end else begin
			if (wr_high)
				tgt_high_r <= {4'h0, reg_wdata[3:0]};
			if (wr_low)
				tgt_low_r <= reg_wdata;
			if (wr_vcfg)
				vcfg_r <= reg_wdata;
			if (wr_str)
				strength_r <= reg_wdata[1:0];
			if (wr_seq0)
				seq0_r <= reg_wdata;
			if (wr_seq1)
				seq1_r <= reg_wdata;
			if (wr_ovr)
				ovr_r <= reg_wdata[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Target code assembly and range clamping.
	wire [11:0] raw_code = {tgt_high_r[3:0], tgt_low_r};
	wire [11:0] code_min = div_sel ? vtarget_pkg::CODE_MIN_DIV20 : vtarget_pkg::CODE_MIN_DIV10;
	wire [11:0] code_max = div_sel ? vtarget_pkg::CODE_MAX_DIV20 : vtarget_pkg::CODE_MAX_DIV10;
	wire below_min = raw_code < code_min;
	wire above_max = raw_code > code_max;
	wire [11:0] target_code = below_min ? code_min : (above_max ? code_max : raw_code);
	assign step_mv = div_sel ? 5'(vtarget_pkg::STEP_MV_DIV20) : 5'(vtarget_pkg::STEP_MV_DIV10);

	// Read data stand for the one cycle after the read strobe.
	wire [7:0] status_word = {4'h0, ramp_state == vtarget_pkg::RAMP_DOWN, ramp_active, conv_running, feedback_sel_r};
	wire [7:0] rd_mux =
		reg_addr == vtarget_pkg::OFS_TARGET_HIGH ? {4'h0, target_code[11:8]} :
		reg_addr == vtarget_pkg::OFS_TARGET_LOW ? target_code[7:0] :
		reg_addr == vtarget_pkg::OFS_VENDOR_CFG ? vcfg_r :
		reg_addr == vtarget_pkg::OFS_DISCH_STRENGTH ? {6'h00, strength_r} :
		reg_addr == vtarget_pkg::OFS_DISCH_SEQ0 ? seq0_r :
		reg_addr == vtarget_pkg::OFS_DISCH_SEQ1 ? seq1_r :
		reg_addr == vtarget_pkg::OFS_DISCH_OVERRIDE ? {6'h00, ovr_r} :
		reg_addr == vtarget_pkg::OFS_STATUS ? status_word : 8'h00;

	always_ff @(posedge mclk) begin
		if (rst)
			rdata_r <= 8'h00;
		else
			rdata_r <= reg_rd ? rd_mux : 8'h00;
	end
	assign reg_rdata = rdata_r;

	////////////////////////////////////////////////////////////////////////////
	// Slope interval divider gives one tick per interval.
	wire [7:0] interval = nvm_slope_interval == 8'h00 ? 8'h01 : nvm_slope_interval;
	assign slope_tick = slope_cnt_r == interval - 8'h01;

	always_ff @(posedge mclk) begin
		if (rst || !conv_running || slope_tick)
			slope_cnt_r <= 8'h00;
		else
			slope_cnt_r <= slope_cnt_r + 8'h01;
	end

	// Reference slewing.
	wire [11:0] diff_up = target_code - ref_r;
	wire [11:0] diff_dn = ref_r - target_code;
	wire [11:0] step_c = 12'(RAMP_STEP);

	always_comb begin
		ramp_state = vtarget_pkg::RAMP_IDLE;
		if (conv_running && target_code > ref_r)
			ramp_state = vtarget_pkg::RAMP_UP;
		else if (conv_running && target_code < ref_r)
			ramp_state = vtarget_pkg::RAMP_DOWN;
	end

	always_comb begin
		ref_nxt = ref_r;
		case (ramp_state)
			vtarget_pkg::RAMP_IDLE: begin
				if (!conv_running)
					ref_nxt = target_code;
			end
			vtarget_pkg::RAMP_UP: begin
				if (slope_tick)
					ref_nxt = diff_up < step_c ? target_code : ref_r + step_c;
			end
			vtarget_pkg::RAMP_DOWN: begin
				if (slope_tick)
					ref_nxt = diff_dn < step_c ? target_code : ref_r - step_c;
			end
			default: ref_nxt = ref_r;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst)
			ref_r <= {vtarget_pkg::RST_TARGET_HIGH[3:0], vtarget_pkg::RST_TARGET_LOW};
		else
			ref_r <= ref_nxt;
	end
	assign reference_code = ref_r;
	assign ramp_active = ramp_state != vtarget_pkg::RAMP_IDLE;
	assign neg_current_block = power_save_operation;

	////////////////////////////////////////////////////////////////////////////
	// Discharge control: override, then active falling ramp, then sequence.
	wire seq_disch = (!conv_running && seq0_r[vtarget_pkg::BIT_SEQ_OFF])
		|| (!en_sync_r && seq1_r[vtarget_pkg::BIT_SEQ_DISABLED]);
	wire slew_disch = nvm_active_slew && ramp_state == vtarget_pkg::RAMP_DOWN;

	always_comb begin
		disch_nxt.en = seq_disch;
		disch_nxt.strength = strength_r;
		if (slew_disch) begin
			disch_nxt.en = 1'b1;
			disch_nxt.strength = vtarget_pkg::STRENGTH_MAX;
		end
		if (ovr_r[vtarget_pkg::BIT_OVR_EN])
			disch_nxt.en = ovr_r[vtarget_pkg::BIT_OVR_ON];
	end

	always_ff @(posedge mclk) begin
		if (rst)
			disch_r <= '0;
		else
			disch_r <= disch_nxt;
	end
	assign discharge = disch_r;

	////////////////////////////////////////////////////////////////////////////
	// Assertions.
	property p_feedback_hold;
		@(posedge mclk) disable iff (rst) (en_sync_r || conv_running) |=> $stable(feedback_sel_r);
	endproperty
	a_feedback_hold: assert property (p_feedback_hold) else $error("feedback choice changed while enabled");

	property p_sense;
		@(posedge mclk) disable iff (rst) loop_sense_vout == internal_feedback_sel;
	endproperty
	a_sense: assert property (p_sense) else $error("loop sense source disagrees with choice");

	property p_range10;
		@(posedge mclk) disable iff (rst) !div_sel |-> target_code >= 12'h064 && target_code <= 12'h960 && step_mv == 5'h0A;
	endproperty
	a_range10: assert property (p_range10) else $error("low range target or step wrong");

	property p_range20;
		@(posedge mclk) disable iff (rst) div_sel |-> target_code >= 12'h0A5 && target_code <= 12'h960 && step_mv == 5'h14;
	endproperty
	a_range20: assert property (p_range20) else $error("high range target or step wrong");

	property p_code;
		@(posedge mclk) disable iff (rst) (!below_min && !above_max) |-> target_code == {tgt_high_r[3:0], tgt_low_r};
	endproperty
	a_code: assert property (p_code) else $error("target code assembly wrong");

	property p_clamp_lo;
		@(posedge mclk) disable iff (rst) (reg_rd && reg_addr == vtarget_pkg::OFS_TARGET_LOW && below_min && !wr_vcfg)
			|=> reg_rdata == $past(code_min[7:0]);
	endproperty
	a_clamp_lo: assert property (p_clamp_lo) else $error("low clamp readback wrong");

	property p_clamp_hi;
		@(posedge mclk) disable iff (rst) (reg_rd && reg_addr == vtarget_pkg::OFS_TARGET_HIGH && above_max)
			|=> reg_rdata == {4'h0, $past(code_max[11:8])};
	endproperty
	a_clamp_hi: assert property (p_clamp_hi) else $error("high clamp readback wrong");

	property p_slew;
		@(posedge mclk) disable iff (rst) $past(conv_running) && conv_running
			|-> (ref_r - $past(ref_r) <= step_c) || ($past(ref_r) - ref_r <= step_c);
	endproperty
	a_slew: assert property (p_slew) else $error("reference jumped more than one step");

	property p_no_move;
		@(posedge mclk) disable iff (rst) (conv_running && !slope_tick) |=> ref_r == $past(ref_r);
	endproperty
	a_no_move: assert property (p_no_move) else $error("reference moved between ticks");

	property p_off_load;
		@(posedge mclk) disable iff (rst) !conv_running |=> ref_r == $past(target_code);
	endproperty
	a_off_load: assert property (p_off_load) else $error("reference not loaded while off");

	property p_slew_disch;
		@(posedge mclk) disable iff (rst) (slew_disch && !ovr_r[vtarget_pkg::BIT_OVR_EN])
			|=> discharge.en && discharge.strength == 2'h3;
	endproperty
	a_slew_disch: assert property (p_slew_disch) else $error("active falling ramp lacks full discharge");

	property p_slew_off;
		@(posedge mclk) disable iff (rst) (!slew_disch && !seq_disch && !ovr_r[vtarget_pkg::BIT_OVR_EN])
			|=> !discharge.en;
	endproperty
	a_slew_off: assert property (p_slew_off) else $error("discharge on outside a falling ramp");

	property p_override;
		@(posedge mclk) disable iff (rst) ovr_r[vtarget_pkg::BIT_OVR_EN] |=> discharge.en == $past(ovr_r[1]);
	endproperty
	a_override: assert property (p_override) else $error("override not applied");

	property p_power_save;
		@(posedge mclk) disable iff (rst) neg_current_block == power_save_operation;
	endproperty
	a_power_save: assert property (p_power_save) else $error("negative current block wrong");

	property p_settle;
		@(posedge mclk) disable iff (rst) (ramp_state == vtarget_pkg::RAMP_UP && slope_tick && diff_up <= step_c)
			|=> ref_r == $past(target_code);
	endproperty
	a_settle: assert property (p_settle) else $error("ramp overshot or missed target");

	c_ramp_up: cover property (@(posedge mclk) disable iff (rst) ramp_state == vtarget_pkg::RAMP_UP ##1 !ramp_active);
	c_ramp_down: cover property (@(posedge mclk) disable iff (rst) slew_disch ##1 discharge.en);
	c_clamp: cover property (@(posedge mclk) disable iff (rst) reg_rd && below_min);
	c_feedback_latch: cover property (@(posedge mclk) disable iff (rst) feedback_sel_r && conv_running);
endmodule
`default_nettype wire

//--- verification/output_voltage_target_dvs_bench.sv
// Self-checking bench for the output voltage target block.
`default_nettype none
module output_voltage_target_dvs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic sense_pin = 1'b1;
	logic en_pin = 1'b0;
	logic running = 1'b0;
	logic psave = 1'b0;
	logic active_slew = 1'b0;
	logic [7:0] interval = 8'h02;
	logic internal_feedback_sel;
	logic loop_sense_vout;
	logic [11:0] reference_code;
	logic [4:0] step_mv;
	logic ramp_active;
	logic neg_current_block;
	vtarget_pkg::disch_s discharge;
	int fail_count = 0;
	int tests_run = 0;
	int cycles = 0;

	output_voltage_target_dvs #(.RAMP_STEP(1)) dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.feedback_sense_pin(sense_pin), .enable_pin(en_pin), .conv_running(running),
		.power_save_operation(psave), .nvm_active_slew(active_slew), .nvm_slope_interval(interval),
		.internal_feedback_sel(internal_feedback_sel), .loop_sense_vout(loop_sense_vout),
		.reference_code(reference_code), .step_mv(step_mv), .ramp_active(ramp_active),
		.neg_current_block(neg_current_block), .discharge(discharge));

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #12.5 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		if (fail_count == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp);
	endtask

	task automatic wr_target(input logic [11:0] c);
		wr(vtarget_pkg::OFS_TARGET_HIGH, {4'h0, c[11:8]});
		wr(vtarget_pkg::OFS_TARGET_LOW, c[7:0]);
	endtask

	// Follows the reference until it settles, flagging any jump larger than one code.
	task automatic ramp_to(input logic [11:0] exp);
		logic [11:0] prev;
		int n;
		prev = reference_code;
		n = 0;
		while ((reference_code !== exp || ramp_active !== 1'b0) && n < 600) begin
			tick(1);
			if (reference_code > prev + 12'h001 || prev > reference_code + 12'h001) begin
				check(reference_code, prev);
			end
			prev = reference_code;
			n++;
		end
		check(reference_code, exp);
		tick(3);
		check(reference_code, exp);
		check(ramp_active, 16'h0000);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		tick(4);
		check(reference_code, 16'h01F4);
		check(internal_feedback_sel, 16'h0001);
		check(loop_sense_vout, 16'h0001);
		rd_chk(vtarget_pkg::OFS_TARGET_HIGH, 8'h01);
		rd_chk(vtarget_pkg::OFS_TARGET_LOW, 8'hF4);
		tick(1);
		check(reg_rdata, 16'h0000);
		rd_chk(vtarget_pkg::OFS_VENDOR_CFG, 8'h00);
		rd_chk(8'h20, 8'h00);
		@(posedge mclk);
		en_pin <= 1'b1;
		tick(4);
		@(posedge mclk);
		sense_pin <= 1'b0;
		tick(5);
		check(internal_feedback_sel, 16'h0001);
		check(step_mv, 16'h000A);
		wr_target(12'h010);
		rd_chk(vtarget_pkg::OFS_TARGET_LOW, 8'h64);
		wr_target(12'hFFF);
		rd_chk(vtarget_pkg::OFS_TARGET_HIGH, 8'h09);
		rd_chk(vtarget_pkg::OFS_TARGET_LOW, 8'h60);
		check(reference_code, 16'h0960);
		wr(vtarget_pkg::OFS_VENDOR_CFG, 8'h01);
		tick(1);
		check(step_mv, 16'h0014);
		wr_target(12'h000);
		rd_chk(vtarget_pkg::OFS_TARGET_LOW, 8'hA5);
		wr(vtarget_pkg::OFS_VENDOR_CFG, 8'h00);
		wr_target(12'h064);
		tick(2);
		check(reference_code, 16'h0064);
		@(posedge mclk);
		running <= 1'b1;
		wr(vtarget_pkg::OFS_TARGET_LOW, 8'hC8);
		tick(1);
		check(ramp_active, 16'h0001);
		rd_chk(vtarget_pkg::OFS_STATUS, 8'h07);
		tick(40);
		check(reference_code > 12'h064 && reference_code < 12'h0C8, 16'h0001);
		check(reference_code, 16'h0079);
		wr(vtarget_pkg::OFS_TARGET_LOW, 8'h70);
		tick(2);
		check(discharge.en, 16'h0000);
		ramp_to(12'h070);
		@(posedge mclk);
		active_slew <= 1'b1;
		wr(vtarget_pkg::OFS_DISCH_STRENGTH, 8'h01);
		wr(vtarget_pkg::OFS_TARGET_LOW, 8'h64);
		tick(3);
		check(discharge, 16'h0007);
		rd_chk(vtarget_pkg::OFS_STATUS, 8'h0F);
		ramp_to(12'h064);
		check(discharge, 16'h0001);
		wr(vtarget_pkg::OFS_TARGET_LOW, 8'h70);
		tick(3);
		check(discharge.en, 16'h0000);
		ramp_to(12'h070);
		wr(vtarget_pkg::OFS_DISCH_OVERRIDE, 8'h03);
		tick(2);
		check(discharge.en, 16'h0001);
		@(posedge mclk);
		running <= 1'b0;
		wr(vtarget_pkg::OFS_DISCH_SEQ0, 8'h01);
		wr(vtarget_pkg::OFS_DISCH_OVERRIDE, 8'h01);
		tick(2);
		check(discharge.en, 16'h0000);
		wr(vtarget_pkg::OFS_DISCH_OVERRIDE, 8'h00);
		tick(2);
		check(discharge, 16'h0005);
		wr(vtarget_pkg::OFS_DISCH_SEQ0, 8'h00);
		wr(vtarget_pkg::OFS_DISCH_SEQ1, 8'h01);
		@(posedge mclk);
		en_pin <= 1'b0;
		psave <= 1'b1;
		tick(5);
		check(discharge, 16'h0005);
		check(neg_current_block, 16'h0001);
		check(internal_feedback_sel, 16'h0000);
		check(loop_sense_vout, 16'h0000);
		complete_run();
	end
endmodule
`default_nettype wire
